// File: lmb_pkg.sv
// lmb_pkg: constants and types of the local memory bus cycle logic.
// assumes one 125 MHz core clock standing in for the oscillator input.
// What this block does
// RULE1 - reset copies boot select level into boot flag
// RULE2 - boot flag high: chapters 0,31 RAM, low ROM
// RULE3 - RAM boot: no bus access while halt set
// RULE4 - divider select held high; low level reserved
// RULE5 - high lane: AX4,A0-A6, status, then D0-D7
// RULE6 - high lane msb on line zero
// RULE7 - low lane: A7-A14, AX4,A0-A6, then D8-D15
// RULE8 - low lane msb on line zero
// RULE9 - full 20-bit address valid at cycle start
// RULE10 - strobe falling edge marks address capture point
// RULE11 - external transparent latches may hold the address
// RULE12 - first ext line: AX0 quarter one, else A12
// RULE13 - second ext line: AX2 quarter one, else A14
// RULE14 - external logic may latch first ext line
// RULE15 - high parity line: AX1, AX0, then parity
// RULE16 - low parity line: AX3, AX2, then parity
// RULE17 - bus clocks divide by eight, second lags quarter
// RULE18 - each cycle runs four equal quarter phases
package lmb_pkg;
  localparam int unsigned ADDR_W       = 20;  // word address width
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CNT_W        = 4;   // core clocks per cycle 16
  localparam int unsigned QTR_LEN      = 4;   // core clocks per quarter
  localparam int unsigned BCLK_DIV     = 8;   // bus clock divide ratio
  localparam int unsigned CHAP_W       = 5;   // chapter = top address bits
  localparam logic [4:0]  CHAP_LOW     = 5'h00;
  localparam logic [4:0]  CHAP_HIGH    = 5'h1f;
  localparam logic [3:0]  CNT_LAST     = 4'hf;
  localparam logic [3:0]  STROBE_FALL  = 4'h2; // strobe low from here on
  localparam logic        PARITY_ODD   = 1'b1; // parity sense of data bytes
  typedef enum logic [1:0] {
    LMB_Q1, LMB_Q2, LMB_Q3, LMB_Q4
  } lmb_qtr_t;
endpackage

// File: lmb_cycle_timer.sv
// lmb_cycle_timer: free running memory cycle phase counter.
// assumes core_clk plays the oscillator role; runs from reset on.
`timescale 1ns/10ps
module lmb_cycle_timer
  import lmb_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // phase
  output logic [CNT_W-1:0]      cnt_q,
  output lmb_qtr_t              qtr,
  output logic                  cycle_end
);
  ////////////////////////////////////////////////////////////////////////
  // counter wraps every cycle; each quarter is QTR_LEN clocks [RULE18]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign qtr       = lmb_qtr_t'(cnt_q[CNT_W-1 -: 2]); // [RULE18]
  assign cycle_end = (cnt_q == CNT_LAST);
endmodule // lmb_cycle_timer

// File: lmb_bus_mux.sv
// lmb_bus_mux: multiplexes address, status and data onto local memory pins.
// assumes requests from the core side, and pins one clock behind the phase
// counter since every pin is driven straight from a flip-flop.
`timescale 1ns/10ps
module lmb_bus_mux
  import lmb_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // strap and control levels
  input  wire logic               boot_select_input,
  input  wire logic               adapter_reset_bit,
  input  wire logic               processor_halt_bit,
  input  wire logic               clock_divider_select,
  output logic                    boot_flag_q,
  output logic                    bus_denied_q,
  // core request side
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [DATA_W-1:0]  req_wdata,
  input  wire logic [7:0]         req_status,
  output logic                    req_taken_q,
  output logic                    rd_done_q,
  output logic [DATA_W-1:0]       rd_data_q,
  output logic                    rd_parity_err_q,
  output logic                    rom_cycle_q,
  // local bus clocks
  output logic                    local_bus_clock_one,
  output logic                    local_bus_clock_two,
  // address latch strobe and extended address lines
  output logic                    address_latch_strobe,
  output logic                    ext_addr_line_first,
  output logic                    ext_addr_line_second,
  // high byte lane, line 0 is the msb
  input  wire logic [0:7]         mem_high_byte_lane_in,
  output logic [0:7]              mem_high_byte_lane_out,
  output logic                    mem_high_byte_lane_oe,
  // low byte lane, line 0 is the msb
  input  wire logic [0:7]         mem_low_byte_lane_in,
  output logic [0:7]              mem_low_byte_lane_out,
  output logic                    mem_low_byte_lane_oe,
  // parity and extended lines
  input  wire logic               ext_parity_line_high_in,
  output logic                    ext_parity_line_high_out,
  output logic                    ext_parity_line_high_oe,
  input  wire logic               ext_parity_line_low_in,
  output logic                    ext_parity_line_low_out,
  output logic                    ext_parity_line_low_oe
);
  logic [CNT_W-1:0]   cnt_q;
  lmb_qtr_t           qtr;
  logic               cycle_end;
  logic               active_q;
  logic               wr_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]  wdata_q;
  logic [7:0]         status_q;
  logic [4:0]         ax;       // AX0..AX4 in index order
  logic [0:14]        a;        // A0..A14, A0 is the msb
  logic               allow;
  logic               ram_chap;
  logic               par_hi;
  logic               par_lo;

  // phase counter shared by every pin process below
  lmb_cycle_timer i_lmb_cycle_timer (
    .core_clk  (core_clk),
    .reset     (reset),
    .cnt_q     (cnt_q),
    .qtr       (qtr),
    .cycle_end (cycle_end)
  );

  ////////////////////////////////////////////////////////////////////////
  // address split: top five bits are AX4..AX0, then A0 down to A14
  assign ax       = addr_q[ADDR_W-1 -: CHAP_W];
  assign a        = addr_q[14:0];
  assign par_hi   = ^wdata_q[15:8] ^ PARITY_ODD;
  assign par_lo   = ^wdata_q[7:0] ^ PARITY_ODD;
  // divider select low is reserved; treated as a bus stop, not a rate
  assign allow    = !(boot_flag_q && processor_halt_bit)   // [RULE3]
                    && clock_divider_select;               // [RULE4]
  assign ram_chap = (req_addr[ADDR_W-1 -: CHAP_W] == CHAP_LOW) ||
                    (req_addr[ADDR_W-1 -: CHAP_W] == CHAP_HIGH);

  ////////////////////////////////////////////////////////////////////////
  // boot flag taken from the strap at either reset source
  always_ff @(posedge core_clk) begin
    if (reset || adapter_reset_bit) begin
      boot_flag_q <= boot_select_input;                    // [RULE1]
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_denied_q <= 1'b1;
    end else begin
      bus_denied_q <= !allow;                              // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request taken only at a cycle boundary, so the address is whole
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_q    <= 1'b0;
      wr_q        <= 1'b0;
      addr_q      <= '0;
      wdata_q     <= '0;
      status_q    <= '0;
      req_taken_q <= 1'b0;
      rom_cycle_q <= 1'b0;
    end else begin
      req_taken_q <= 1'b0;
      if (cycle_end) begin
        active_q    <= req_valid && allow;                 // [RULE3]
        req_taken_q <= req_valid && allow;
        if (req_valid && allow) begin
          wr_q        <= req_write;
          addr_q      <= req_addr;
          wdata_q     <= req_wdata;
          status_q    <= req_status;
          rom_cycle_q <= ram_chap && !boot_flag_q;          // [RULE2]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data sampled at the end of quarter four
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_done_q       <= 1'b0;
      rd_data_q       <= '0;
      rd_parity_err_q <= 1'b0;
    end else begin
      rd_done_q <= active_q && !wr_q && cycle_end;
      if (active_q && !wr_q && cycle_end) begin
        rd_data_q <= {mem_high_byte_lane_in, mem_low_byte_lane_in};
        rd_parity_err_q <=
          ((^mem_high_byte_lane_in ^ PARITY_ODD) != ext_parity_line_high_in)
          || ((^mem_low_byte_lane_in ^ PARITY_ODD) != ext_parity_line_low_in);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus clocks: high for half of eight counts, second two counts later
  always_ff @(posedge core_clk) begin
    if (reset) begin
      local_bus_clock_one <= 1'b0;
      local_bus_clock_two <= 1'b0;
    end else begin
      local_bus_clock_one <= (cnt_q[2:0] < 3'h4);              // [RULE17]
      local_bus_clock_two <= (cnt_q[2:0] >= 3'h2) &&
                             (cnt_q[2:0] < 3'h6);              // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe high while the address settles, falls within quarter one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      address_latch_strobe <= 1'b0;
    end else begin
      address_latch_strobe <= active_q && (cnt_q < STROBE_FALL); // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per quarter line selection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_addr_line_first      <= 1'b0;
      ext_addr_line_second     <= 1'b0;
      mem_high_byte_lane_out   <= '0;
      mem_low_byte_lane_out    <= '0;
      ext_parity_line_high_out <= 1'b0;
      ext_parity_line_low_out  <= 1'b0;
    end else begin
      unique case (qtr)
        LMB_Q1: begin  // row time: whole address at once [RULE9]
          ext_addr_line_first      <= ax[0];               // [RULE12]
          ext_addr_line_second     <= ax[2];               // [RULE13]
          mem_high_byte_lane_out   <= {ax[4], a[0:6]};     // [RULE5] [RULE6]
          mem_low_byte_lane_out    <= a[7:14];             // [RULE7] [RULE8]
          ext_parity_line_high_out <= ax[1];               // [RULE15]
          ext_parity_line_low_out  <= ax[3];               // [RULE16]
        end
        LMB_Q2: begin
          ext_addr_line_first      <= a[12];               // [RULE12]
          ext_addr_line_second     <= a[14];               // [RULE13]
          mem_high_byte_lane_out   <= status_q;            // [RULE5]
          mem_low_byte_lane_out    <= {ax[4], a[0:6]};     // [RULE7] [RULE8]
          ext_parity_line_high_out <= ax[0];               // [RULE15]
          ext_parity_line_low_out  <= ax[2];               // [RULE16]
        end
        LMB_Q3, LMB_Q4: begin
          ext_addr_line_first      <= a[12];               // [RULE12]
          ext_addr_line_second     <= a[14];               // [RULE13]
          mem_high_byte_lane_out   <= wdata_q[15:8];       // [RULE5] [RULE6]
          mem_low_byte_lane_out    <= wdata_q[7:0];        // [RULE7] [RULE8]
          ext_parity_line_high_out <= par_hi;              // [RULE15]
          ext_parity_line_low_out  <= par_lo;              // [RULE16]
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enables: address half driven on every access, data half only on writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_high_byte_lane_oe   <= 1'b0;
      mem_low_byte_lane_oe    <= 1'b0;
      ext_parity_line_high_oe <= 1'b0;
      ext_parity_line_low_oe  <= 1'b0;
    end else begin
      mem_high_byte_lane_oe   <= active_q && (!cnt_q[3] || wr_q); // [RULE18]
      mem_low_byte_lane_oe    <= active_q && (!cnt_q[3] || wr_q);
      ext_parity_line_high_oe <= active_q && (!cnt_q[3] || wr_q);
      ext_parity_line_low_oe  <= active_q && (!cnt_q[3] || wr_q);
    end
  end
endmodule // lmb_bus_mux

// File: lmb_checker.sv
// lmb_checker: port assertions for the local memory bus mux.
// assumes a bind onto lmb_bus_mux and its single core clock.
`timescale 1ns/10ps
module lmb_checker (
  // clock, reset and control levels
  input wire logic core_clk,
  input wire logic reset,
  input wire logic boot_select_input,
  input wire logic adapter_reset_bit,
  input wire logic processor_halt_bit,
  input wire logic clock_divider_select,
  // watched outputs
  input wire logic boot_flag_q,
  input wire logic bus_denied_q,
  input wire logic req_taken_q,
  input wire logic address_latch_strobe,
  input wire logic ext_addr_line_first,
  input wire logic ext_addr_line_second,
  input wire logic local_bus_clock_one,
  input wire logic local_bus_clock_two
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // strobe steps: two clocks high, then low for the next eight clocks
  sequence s_stb_high; address_latch_strobe [*2]; endsequence
  sequence s_stb_low;  !address_latch_strobe [*8]; endsequence
  property p_strobe;
    $rose(address_latch_strobe) |-> s_stb_high ##1 s_stb_low;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("latch strobe shape wrong");
  property p_spacing; req_taken_q |=> !req_taken_q [*8]; endproperty
  a_spacing: assert property (p_spacing)
    else $error("requests taken too close");
  // column-time values hold from quarter two onwards
  property p_first;
    $rose(address_latch_strobe) |-> ##5 $stable(ext_addr_line_first) [*8];
  endproperty
  a_first: assert property (p_first)
    else $error("first ext line moved");
  property p_second;
    $rose(address_latch_strobe) |-> ##5 $stable(ext_addr_line_second) [*8];
  endproperty
  a_second: assert property (p_second)
    else $error("second ext line moved");
  property p_bclk;
    $rose(local_bus_clock_one) |-> local_bus_clock_one [*4]
      ##1 !local_bus_clock_one [*4] ##1 local_bus_clock_one;
  endproperty
  a_bclk: assert property (p_bclk)
    else $error("bus clock one period wrong");
  property p_lag;
    $rose(local_bus_clock_one) |-> ##2 $rose(local_bus_clock_two);
  endproperty
  a_lag: assert property (p_lag)
    else $error("bus clock two lag wrong");
  property p_denied; req_taken_q |-> !$past(bus_denied_q); endproperty
  a_denied: assert property (p_denied)
    else $error("request taken while denied");
  property p_halt; boot_flag_q && processor_halt_bit |=> bus_denied_q;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not deny bus");
  property p_div; !clock_divider_select |=> bus_denied_q; endproperty
  a_div: assert property (p_div)
    else $error("reserved divider level not denied");
  property p_boot;
    adapter_reset_bit |=> boot_flag_q == $past(boot_select_input);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot flag missed strap");
endmodule // lmb_checker

// File: lmb_mem_model.sv
// lmb_mem_model: small local memory with address latch on the far side.
// assumes the mux pin timing; powers up idle, needs no reset.
`timescale 1ns/10ps
module lmb_mem_model (
  // clock, strobe and fault command
  input  wire logic       core_clk,
  input  wire logic       address_latch_strobe,
  input  wire logic       bad_parity,
  // pins driven by the mux
  input  wire logic       ext_first,
  input  wire logic [0:7] hi_out,
  input  wire logic [0:7] lo_out,
  input  wire logic       hi_oe,
  input  wire logic       lo_oe,
  input  wire logic       ph_out,
  input  wire logic       ph_oe,
  input  wire logic       pl_out,
  input  wire logic       pl_oe,
  // wire levels back to the mux
  output logic [0:7]      hi_in,
  output logic [0:7]      lo_in,
  output logic            ph_in,
  output logic            pl_in
);
  logic [3:0]  ph_q = 4'hf;
  logic        stb_q = 1'b0;
  logic        row_x_q = 1'b0;
  logic [4:0]  adr_q = 5'h00;
  logic [17:0] last_q = 18'h00000;
  logic [15:0] mem_q [0:63];
  logic        drv;
  logic [15:0] rd;
  ////////////////////////////////////////////////////////////////////////
  // phase counts from strobe rise and parks at 15 so idle stays quiet
  always_ff @(posedge core_clk) begin
    stb_q <= address_latch_strobe;
    if (address_latch_strobe && !stb_q) begin
      ph_q <= 4'h1;
    end else if (ph_q != 4'hf) begin
      ph_q <= ph_q + 4'h1;
    end
  end
  // latches follow the lines while the strobe is high; the strobe also
  // stands in for the row strobe that keeps the first ext line
  always_ff @(posedge core_clk) begin
    if (address_latch_strobe) begin
      adr_q   <= lo_out[3:7];
      row_x_q <= ext_first;
    end
  end
  // write data taken mid data phase, once the lanes have settled
  always_ff @(posedge core_clk) begin
    if (ph_q == 4'hc && hi_oe) begin
      mem_q[{row_x_q, adr_q}] <= {hi_out, lo_out};
    end
    last_q <= {hi_in, lo_in, ph_in, pl_in};
  end
  // released lines show the inverse of their last level
  assign drv   = ph_q[3] && ph_q != 4'hf && !hi_oe;
  assign rd    = drv ? mem_q[{row_x_q, adr_q}] : ~last_q[17:2];
  assign hi_in = hi_oe ? hi_out : rd[15:8];
  assign lo_in = lo_oe ? lo_out : rd[7:0];
  assign ph_in = ph_oe ? ph_out : drv ? ~^rd[15:8] ^ bad_parity : ~last_q[1];
  assign pl_in = pl_oe ? pl_out : drv ? ~^rd[7:0] : ~last_q[0];
endmodule // lmb_mem_model

// File: test_local_memory_bus_mux.sv
// test_local_memory_bus_mux: directed bench for lmb_bus_mux.
// assumes lmb_pkg, lmb_mem_model and lmb_checker are compiled first.
`timescale 1ns/10ps
module test_local_memory_bus_mux;
  import lmb_pkg::*;
  logic core_clk, reset, boot_select_input, adapter_reset_bit, bad_par;
  logic processor_halt_bit, clock_divider_select, req_valid, req_write;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data_q;
  logic [7:0] req_status;
  logic boot_flag_q, bus_denied_q, req_taken_q, rd_done_q, rd_parity_err_q;
  logic rom_cycle_q, local_bus_clock_one, local_bus_clock_two;
  logic address_latch_strobe, ext_addr_line_first, ext_addr_line_second;
  logic [0:7] mem_high_byte_lane_in, mem_high_byte_lane_out;
  logic [0:7] mem_low_byte_lane_in, mem_low_byte_lane_out;
  logic mem_high_byte_lane_oe, mem_low_byte_lane_oe;
  logic ext_parity_line_high_in, ext_parity_line_high_out;
  logic ext_parity_line_high_oe, ext_parity_line_low_in;
  logic ext_parity_line_low_out, ext_parity_line_low_oe;
  int errors = 0;
  int checks_done = 0;
  lmb_bus_mux i_lmb_bus_mux (.*);
  lmb_mem_model i_lmb_mem_model (.core_clk, .address_latch_strobe,
    .bad_parity(bad_par), .ext_first(ext_addr_line_first),
    .hi_out(mem_high_byte_lane_out),
    .lo_out(mem_low_byte_lane_out), .hi_oe(mem_high_byte_lane_oe),
    .lo_oe(mem_low_byte_lane_oe), .ph_out(ext_parity_line_high_out),
    .ph_oe(ext_parity_line_high_oe), .pl_out(ext_parity_line_low_out),
    .pl_oe(ext_parity_line_low_oe), .hi_in(mem_high_byte_lane_in),
    .lo_in(mem_low_byte_lane_in), .ph_in(ext_parity_line_high_in),
    .pl_in(ext_parity_line_low_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] pins();
    return {mem_high_byte_lane_out, mem_low_byte_lane_out,
      ext_addr_line_first, ext_addr_line_second,
      ext_parity_line_high_out, ext_parity_line_low_out};
  endfunction
  // all four lane and parity enables, high lane first
  function automatic logic [3:0] oes();
    return {mem_high_byte_lane_oe, mem_low_byte_lane_oe,
      ext_parity_line_high_oe, ext_parity_line_low_oe};
  endfunction
  // one memory cycle; every wait is bounded so a hang ends the run
  task automatic access(input logic wr, input logic [19:0] a,
                        input logic [15:0] d, input logic rom);
    int n;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    req_status = 8'h96;
    for (n = 0; req_taken_q !== 1'b1; n++) begin
      if (n > 40) begin
        errors++;
        wrap_up();
      end
      @(negedge core_clk);
    end
    req_valid = 1'b0;
    for (n = 0; address_latch_strobe !== 1'b1; n++) begin
      if (n > 8) begin
        errors++;
        wrap_up();
      end
      @(negedge core_clk);
    end
    chk(rom_cycle_q, rom);
    chk(pins(), {a[19], a[14:0], a[15], a[17], a[16], a[18]});
    chk(oes(), 4'hf);
    repeat (4) @(negedge core_clk);
    chk(pins(), {8'h96, a[19], a[14:8], a[2], a[0], a[15], a[17]});
    repeat (4) @(negedge core_clk);
    chk(oes(), {4{wr}});
    if (wr) chk(pins(), {d, a[2], a[0], ~^d[15:8], ~^d[7:0]});
    for (n = 0; !wr && rd_done_q !== 1'b1; n++) begin
      if (n > 24) begin
        errors++;
        wrap_up();
      end
      @(negedge core_clk);
    end
    if (!wr) chk({rd_parity_err_q, rd_data_q}, {bad_par, d});
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // inputs move on the falling edge, away from the sampling edge
  initial begin
    reset = 1'b1;
    boot_select_input = 1'b1;
    adapter_reset_bit = 1'b0;
    processor_halt_bit = 1'b1;
    clock_divider_select = 1'b1;
    bad_par = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_status = 8'h00;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    chk(boot_flag_q, 1'b1);
    req_valid = 1'b1;
    repeat (40) begin
      @(negedge core_clk);
      chk(req_taken_q, 1'b0);
    end
    req_valid = 1'b0;
    processor_halt_bit = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(bus_denied_q, 1'b0);
    $display("halt test done");
    access(1'b1, 20'h5a3c7, 16'hc3a1, 1'b0);
    access(1'b1, 20'hfc5b8, 16'h1e70, 1'b0);
    access(1'b1, 20'h03a5b, 16'h96e4, 1'b0);
    access(1'b0, 20'h5a3c7, 16'hc3a1, 1'b0);
    bad_par = 1'b1;
    access(1'b0, 20'hfc5b8, 16'h1e70, 1'b0);
    bad_par = 1'b0;
    $display("ram cycle test done");
    adapter_reset_bit = 1'b1;
    boot_select_input = 1'b0;
    repeat (2) @(negedge core_clk);
    adapter_reset_bit = 1'b0;
    processor_halt_bit = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({boot_flag_q, bus_denied_q}, 2'b00);
    access(1'b0, 20'hfc5b8, 16'h1e70, 1'b1);
    access(1'b0, 20'h03a5b, 16'h96e4, 1'b1);
    access(1'b0, 20'h5a3c7, 16'hc3a1, 1'b0);
    clock_divider_select = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(bus_denied_q, 1'b1);
    $display("rom and divider test done");
    wrap_up();
  end
endmodule // test_local_memory_bus_mux
bind lmb_bus_mux lmb_checker i_lmb_checker (.*);
